/* common/ces_pkg.sv */
package ces_pkg;
   typedef enum logic [2:0] {
      CES_IDLE,
      CES_COAST,
      CES_DECEL,
      CES_STOPPED,
      CES_DECEL_AUTO,
      CES_FALLBACK
   } ces_state_t;

   typedef struct packed {
      logic [15:0] retry;
      logic [15:0] check;
      logic [1:0] stopsel;
      logic [15:0] fallbk;
      logic [15:0] maxspd;
      logic [7:0] extdisp;
      logic net;
      logic modbus;
   } ces_cfg_t;

   typedef struct packed {
      logic link_fault_code;
      logic fault_out;
      logic link_alarm_output;
      logic coast;
      logic decel;
      logic fallback;
      logic [15:0] speed;
   } ces_out_t;

   typedef struct packed {
      ces_cfg_t cfg;
      ces_state_t state;
      ces_out_t out;
      logic [3:0] errcnt;
      logic armed;
      logic link_err;
      logic [31:0] prescale;
      logic [15:0] tenths;
      logic [15:0] hold;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic ack;
      logic [31:0] rdat;
   } ces_st_t;
endpackage : ces_pkg

/* common/ces_regs.svh */
`ifndef CES_REGS_SVH
`define CES_REGS_SVH
`define CES_A_CTRL 8'h00
`define CES_A_RETRY 8'h04
`define CES_A_CHECK 8'h08
`define CES_A_STOPSEL 8'h0c
`define CES_A_FALLBK 8'h10
`define CES_A_MAXSPD 8'h14
`define CES_A_EXTDISP 8'h18
`define CES_A_STATUS 8'h1c
`define CES_A_SPEED 8'h20
`define CES_A_IRQ_STAT 8'h24
`define CES_A_IRQ_MASK 8'h28
`define CES_CTRL_NET 0
`define CES_CTRL_MODBUS 1
`define CES_CTRL_CLEAR 2
`define CES_IRQ_TRIP 0
`define CES_IRQ_LINK 1
`define CES_IRQ_ALARM 2
`define CES_DISABLE 16'h270f
`define CES_RETRY_MAX 16'h000a
`define CES_CHECK_MAX 16'h270e
`define CES_FALLBK_MAX_SMALL 16'h2ee0
`define CES_FALLBK_MAX_LARGE 16'h1f40
`define CES_RST_RETRY 16'h0001
`define CES_RST_CHECK 16'h0000
`define CES_RST_STOPSEL 2'h0
`define CES_RST_FALLBK 16'h270f
`define CES_RST_MAXSPD 16'h2ee0
`define CES_RST_EXTDISP 8'h00
`define CES_STEP_NS 100000000
`define CES_CLK_NS 5
`endif

/* hw/ces_supervisor.sv */
// Summary of operation
// - supervision acts only in network mode
// - trip when consecutive receive errors exceed limit
// - disabled retry limit: alarm instead of trip
// - retry counting only with computer-link protocol
// - trip when silence outlasts check interval
// - disabled check interval: no loss detection
// - zero interval faults on entering network mode
// - stop modes coast, decelerate, decelerate-restart
// - mode 3 runs at fallback, resumes after
// - fallback range by unit; 9999 keeps speed
// - fallback speed clamped to motor maximum
// - retry, check, stop-mode and fallback settings writable only when display select zero
// - any frame clears the check timer
// - loss checking starts at first frame
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "ces_regs.svh"

module ces_supervisor #(
   parameter int unsigned TICK_CYCLES = `CES_STEP_NS / `CES_CLK_NS,
   parameter bit LARGE_UNIT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic frame_ok_i,
   input wire logic frame_err_i,
   input wire logic [15:0] speed_cmd_i,
   input wire logic motor_stopped_i,
   output logic link_fault_code_o,
   output logic fault_out_o,
   output logic link_alarm_output_o,
   output logic coast_o,
   output logic decel_o,
   output logic fallback_o,
   output logic [15:0] speed_o,
   output logic irq_o
);

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
   localparam logic [15:0] FALLBK_MAX = LARGE_UNIT ? `CES_FALLBK_MAX_LARGE : `CES_FALLBK_MAX_SMALL;

   ces_pkg::ces_st_t s_q;
   ces_pkg::ces_st_t s_d;

   logic [31:0] rv;
   logic [31:0] wv;
   logic wr;
   logic unlock;
   logic clear_req;
   logic [2:0] w1c;
   logic [2:0] ev;
   logic any_frame;
   logic retry_on;
   logic retry_trip;
   logic alarm_rx;
   logic check_on;
   logic loss_trip;
   logic zero_trip;
   logic link_err;
   logic [15:0] fb;

   function automatic logic [31:0] ces_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : ces_merge

   always_comb
   begin
      s_d = s_q;
      clear_req = 1'b0;
      w1c = 3'h0;
      ev = 3'h0;
      fb = 16'h0000;

      // register read mux; unmapped offsets read as zero
      case (wb_adr_i[7:0])
         `CES_A_CTRL: rv = {30'h0, s_q.cfg.modbus, s_q.cfg.net};
         `CES_A_RETRY: rv = {16'h0, s_q.cfg.retry};
         `CES_A_CHECK: rv = {16'h0, s_q.cfg.check};
         `CES_A_STOPSEL: rv = {30'h0, s_q.cfg.stopsel};
         `CES_A_FALLBK: rv = {16'h0, s_q.cfg.fallbk};
         `CES_A_MAXSPD: rv = {16'h0, s_q.cfg.maxspd};
         `CES_A_EXTDISP: rv = {24'h0, s_q.cfg.extdisp};
         `CES_A_STATUS: rv = {20'h0, s_q.errcnt, 1'b0, s_q.armed, s_q.out.fallback, s_q.out.decel,
                              s_q.out.coast, s_q.out.link_alarm_output, s_q.out.fault_out,
                              s_q.out.link_fault_code};
         `CES_A_SPEED: rv = {16'h0, s_q.out.speed};
         `CES_A_IRQ_STAT: rv = {29'h0, s_q.irq_stat};
         `CES_A_IRQ_MASK: rv = {29'h0, s_q.irq_mask};
         default: rv = 32'h0000_0000;
      endcase
      wv = ces_merge(rv, wb_dat_i, wb_sel_i);

      // ack one cycle after the strobe; the write lands on the edge the master sees ack
      s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
      // read data stays zero outside the ack cycle, so bus data can be ored
      s_d.rdat = s_d.ack ? rv : 32'h0000_0000;
      wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;
      unlock = (s_q.cfg.extdisp == 8'h00);

      if (wr)
      begin
         case (wb_adr_i[7:0])
            `CES_A_CTRL:
            begin
               s_d.cfg.net = wv[`CES_CTRL_NET];
               s_d.cfg.modbus = wv[`CES_CTRL_MODBUS];
               clear_req = wv[`CES_CTRL_CLEAR];
            end
            `CES_A_RETRY:
            begin
               // out-of-range values are dropped so the limit stays meaningful
               if (unlock && (wv[15:0] <= `CES_RETRY_MAX || wv[15:0] == `CES_DISABLE))
               begin
                  s_d.cfg.retry = wv[15:0];
               end
            end
            `CES_A_CHECK:
            begin
               if (unlock && (wv[15:0] <= `CES_CHECK_MAX || wv[15:0] == `CES_DISABLE))
               begin
                  s_d.cfg.check = wv[15:0];
               end
            end
            `CES_A_STOPSEL:
            begin
               if (unlock)
               begin
                  s_d.cfg.stopsel = wv[1:0];
               end
            end
            `CES_A_FALLBK:
            begin
               if (unlock && (wv[15:0] <= FALLBK_MAX || wv[15:0] == `CES_DISABLE))
               begin
                  s_d.cfg.fallbk = wv[15:0];
               end
            end
            `CES_A_MAXSPD: s_d.cfg.maxspd = wv[15:0];
            `CES_A_EXTDISP: s_d.cfg.extdisp = wv[7:0];
            `CES_A_IRQ_STAT:
            begin
               // only a written byte may clear; merged-in status ones must not
               w1c = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
            end
            `CES_A_IRQ_MASK: s_d.irq_mask = wv[2:0];
            default: s_d.irq_mask = s_q.irq_mask;
         endcase
      end

      any_frame = frame_ok_i | frame_err_i;

      // consecutive receive errors; leaving network mode forgets them
      // the count saturates so a long burst cannot wrap under the limit
      if (!s_q.cfg.net)
      begin
         s_d.errcnt = 4'h0;
      end
      else if (frame_ok_i)
      begin
         s_d.errcnt = 4'h0;
      end
      else if (frame_err_i && s_q.errcnt != 4'hf)
      begin
         s_d.errcnt = s_q.errcnt + 4'h1;
      end

      retry_on = s_q.cfg.net & ~s_q.cfg.modbus & (s_q.cfg.retry != `CES_DISABLE);
      retry_trip = retry_on & ({12'h000, s_q.errcnt} > s_q.cfg.retry);
      alarm_rx = s_q.cfg.net & ~s_q.cfg.modbus & (s_q.cfg.retry == `CES_DISABLE)
                 & (s_q.errcnt != 4'h0);

      // loss timer is armed by the first frame seen in network mode
      if (!s_q.cfg.net)
      begin
         s_d.armed = 1'b0;
      end
      else if (any_frame)
      begin
         s_d.armed = 1'b1;
      end

      // zero and the disable value are handled apart; the timer runs only for real intervals
      check_on = s_q.cfg.net & s_q.armed & (s_q.cfg.check != `CES_DISABLE)
                 & (s_q.cfg.check != 16'h0000);
      if (!check_on || any_frame)
      begin
         s_d.prescale = 32'h0000_0000;
         s_d.tenths = 16'h0000;
      end
      else if (s_q.prescale == TICK_LAST)
      begin
         s_d.prescale = 32'h0000_0000;
         if (s_q.tenths != 16'hffff)
         begin
            s_d.tenths = s_q.tenths + 16'h0001;
         end
      end
      else
      begin
         s_d.prescale = s_q.prescale + 32'h0000_0001;
      end
      // strictly greater: silence must outlast the interval
      loss_trip = check_on & (s_q.tenths > s_q.cfg.check);
      zero_trip = s_q.cfg.net & (s_q.cfg.check == 16'h0000);
      link_err = retry_trip | loss_trip | zero_trip;
      s_d.link_err = link_err;

      case (s_q.state)
         ces_pkg::CES_IDLE:
         begin
            if (link_err)
            begin
               ev[`CES_IRQ_TRIP] = 1'b1;
               case (s_q.cfg.stopsel)
                  2'h0: s_d.state = ces_pkg::CES_COAST;
                  2'h1: s_d.state = ces_pkg::CES_DECEL;
                  2'h2: s_d.state = ces_pkg::CES_DECEL_AUTO;
                  default:
                  begin
                     s_d.state = ces_pkg::CES_FALLBACK;
                     s_d.hold = speed_cmd_i;
                  end
               endcase
            end
         end
         ces_pkg::CES_COAST:
         begin
            // latched trip only leaves on a software clear once the error is gone
            if (clear_req && !link_err)
            begin
               s_d.state = ces_pkg::CES_IDLE;
            end
         end
         ces_pkg::CES_DECEL:
         begin
            if (motor_stopped_i)
            begin
               s_d.state = ces_pkg::CES_STOPPED;
            end
         end
         ces_pkg::CES_STOPPED:
         begin
            if (clear_req && !link_err)
            begin
               s_d.state = ces_pkg::CES_IDLE;
            end
         end
         ces_pkg::CES_DECEL_AUTO:
         begin
            // error gone even mid-deceleration: restart at once
            if (!link_err)
            begin
               s_d.state = ces_pkg::CES_IDLE;
            end
         end
         ces_pkg::CES_FALLBACK:
         begin
            if (!link_err)
            begin
               s_d.state = ces_pkg::CES_IDLE;
            end
         end
         default: s_d.state = ces_pkg::CES_IDLE;
      endcase

      s_d.out.coast = (s_d.state == ces_pkg::CES_COAST);
      s_d.out.decel = (s_d.state == ces_pkg::CES_DECEL) || (s_d.state == ces_pkg::CES_STOPPED)
                      || (s_d.state == ces_pkg::CES_DECEL_AUTO);
      s_d.out.fault_out = (s_d.state == ces_pkg::CES_COAST) || (s_d.state == ces_pkg::CES_STOPPED);
      s_d.out.link_fault_code = s_d.out.fault_out
                                || ((s_d.state == ces_pkg::CES_DECEL_AUTO) && motor_stopped_i);
      s_d.out.fallback = (s_d.state == ces_pkg::CES_FALLBACK);
      s_d.out.link_alarm_output = alarm_rx || (s_d.state == ces_pkg::CES_FALLBACK);

      // the clamp applies to a set fallback speed and to the held one alike
      fb = (s_q.cfg.fallbk == `CES_DISABLE) ? s_d.hold : s_q.cfg.fallbk;
      if (fb > s_q.cfg.maxspd)
      begin
         fb = s_q.cfg.maxspd;
      end
      s_d.out.speed = s_d.out.fallback ? fb : speed_cmd_i;

      ev[`CES_IRQ_LINK] = link_err & ~s_q.link_err;
      ev[`CES_IRQ_ALARM] = s_d.out.link_alarm_output & ~s_q.out.link_alarm_output;
      // a new event beats a clear in the same cycle
      s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
   end

   // reset loads the factory defaults of the settings; all else clears
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.state <= ces_pkg::CES_IDLE;
         s_q.cfg.retry <= `CES_RST_RETRY;
         s_q.cfg.check <= `CES_RST_CHECK;
         s_q.cfg.stopsel <= `CES_RST_STOPSEL;
         s_q.cfg.fallbk <= `CES_RST_FALLBK;
         s_q.cfg.maxspd <= `CES_RST_MAXSPD;
         s_q.cfg.extdisp <= `CES_RST_EXTDISP;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.rdat;
   assign wb_ack_o = s_q.ack;
   assign link_fault_code_o = s_q.out.link_fault_code;
   assign fault_out_o = s_q.out.fault_out;
   assign link_alarm_output_o = s_q.out.link_alarm_output;
   assign coast_o = s_q.out.coast;
   assign decel_o = s_q.out.decel;
   assign fallback_o = s_q.out.fallback;
   assign speed_o = s_q.out.speed;
   assign irq_o = s_q.irq;

endmodule : ces_supervisor

/* verification/ces_host_model.sv */
`timescale 1ns/1ps
module ces_host_model (
   input wire logic clk_i,
   output logic frame_ok_o,
   output logic frame_err_o
);
   initial frame_ok_o = 1'b0;
   initial frame_err_o = 1'b0;
   // gap sets how slowly the host talks; a long gap starves the loss timer
   task send(input logic good, input int n, input int gap);
      repeat (n)
      begin
         @(posedge clk_i);
         frame_ok_o <= good;
         frame_err_o <= !good;
         @(posedge clk_i);
         frame_ok_o <= 1'b0;
         frame_err_o <= 1'b0;
         repeat (gap) @(posedge clk_i);
      end
   endtask : send
endmodule : ces_host_model

/* verification/ces_supervisor_assertions.sv */
`timescale 1ns/1ps
module ces_supervisor_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [15:0] speed_cmd_i,
   input wire logic motor_stopped_i,
   input wire logic link_fault_code_o,
   input wire logic fault_out_o,
   input wire logic link_alarm_output_o,
   input wire logic coast_o,
   input wire logic decel_o,
   input wire logic fallback_o,
   input wire logic [15:0] speed_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_coast_flags: assert property (coast_o |-> link_fault_code_o && fault_out_o && !decel_o)
      else $error("coast without fault flags");
   a_fallback_quiet: assert property (fallback_o |-> !fault_out_o && !link_fault_code_o
      && link_alarm_output_o)
      else $error("fallback shows a fault");
   a_speed_follow: assert property (!fallback_o && !$past(fallback_o) && !$past(rst_i)
      |-> speed_o == $past(speed_cmd_i))
      else $error("speed not following command");
   // clear lands on the edge after the acked write; up to three are allowed
   a_fault_latch: assert property ($fell(fault_out_o) |-> $past(wb_ack_o && wb_we_i)
      || $past(wb_ack_o && wb_we_i, 2) || $past(wb_ack_o && wb_we_i, 3))
      else $error("fault output dropped without clear");
   a_decel_first: assert property ($rose(fault_out_o) && decel_o
      |-> $past(motor_stopped_i) || $past(motor_stopped_i, 2))
      else $error("fault output before standstill");
   a_mode2_code: assert property (decel_o && link_fault_code_o && !fault_out_o
      |-> $past(motor_stopped_i))
      else $error("code shown while still moving");
   c_coast: cover property (coast_o);
   c_fallback: cover property (fallback_o);
   c_irq: cover property ($rose(irq_o));
   c_mode2: cover property (decel_o && link_fault_code_o && !fault_out_o);
endmodule : ces_supervisor_assertions

bind ces_supervisor ces_supervisor_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .speed_cmd_i(speed_cmd_i),
   .motor_stopped_i(motor_stopped_i), .link_fault_code_o(link_fault_code_o), .fault_out_o(fault_out_o),
   .link_alarm_output_o(link_alarm_output_o), .coast_o(coast_o), .decel_o(decel_o), .fallback_o(fallback_o),
   .speed_o(speed_o), .irq_o(irq_o));

/* verification/tb_comm_error_supervisor.sv */
`timescale 1ns/1ps
`include "ces_regs.svh"
module tb_comm_error_supervisor;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic stopped = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic [15:0] cmd = 16'h03e8;
   logic [15:0] spd;
   logic f_ok, f_err, ack, code, flt, alm, coast, decel, fb, irq;
   int n_mismatch = 0;
   int num_checks = 0;
   wire [5:0] so = {code, flt, alm, coast, decel, fb};
   always #2.5 clk_i = ~clk_i;
   ces_supervisor #(.TICK_CYCLES(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .frame_ok_i(f_ok), .frame_err_i(f_err), .speed_cmd_i(cmd), .motor_stopped_i(stopped),
      .link_fault_code_o(code), .fault_out_o(flt), .link_alarm_output_o(alm), .coast_o(coast),
      .decel_o(decel), .fallback_o(fb), .speed_o(spd), .irq_o(irq));
   ces_host_model host_u (.clk_i(clk_i), .frame_ok_o(f_ok), .frame_err_o(f_err));
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h0, a};
      wdat <= d;
      // no limit here: only the watchdog ends a wait for ack
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rc
   task wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wt
   task co(input logic [5:0] e);
      chk({26'h0, so}, {26'h0, e});
   endtask : co
   task t_reset;
      logic [7:0] a [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40};
      logic [31:0] e [7] = '{32'h1, 32'h0, 32'h0, 32'h270f, 32'h2ee0, 32'h0, 32'h0};
      wr(8'h40, 32'h1234);
      foreach (a[k]) rc(a[k], e[k]);
   endtask : t_reset
   task t_zero;
      wr(`CES_A_CTRL, 32'h1);
      wt(4);
      co(6'b110100);
      chk({31'h0, irq}, 32'h0);
      wr(`CES_A_CTRL, 32'h0);
      wr(`CES_A_CTRL, 32'h4);
      wt(3);
      co(6'h00);
      wr(`CES_A_IRQ_MASK, 32'h1);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      wr(`CES_A_IRQ_STAT, 32'h7);
      wt(2);
      chk({31'h0, irq}, 32'h0);
   endtask : t_zero
   task t_retry;
      wr(`CES_A_CHECK, 32'h270f);
      wr(`CES_A_STOPSEL, 32'h1);
      wr(`CES_A_CTRL, 32'h1);
      host_u.send(1'b0, 1, 2);
      host_u.send(1'b1, 1, 2);
      host_u.send(1'b0, 1, 2);
      wt(4);
      co(6'h00);
      host_u.send(1'b0, 1, 2);
      wt(4);
      co(6'b000010);
      @(posedge clk_i);
      stopped <= 1'b1;
      wt(4);
      co(6'b110010);
      host_u.send(1'b1, 1, 2);
      wr(`CES_A_CTRL, 32'h5);
      wt(3);
      co(6'h00);
      @(posedge clk_i);
      stopped <= 1'b0;
      wr(`CES_A_RETRY, 32'h270f);
      host_u.send(1'b0, 2, 2);
      wt(4);
      // the alarm terminal is taken as assigned in positive logic
      co(6'b001000);
      host_u.send(1'b1, 1, 2);
      wt(4);
      co(6'h00);
   endtask : t_retry
   task t_fallback;
      wr(`CES_A_STOPSEL, 32'h3);
      wr(`CES_A_FALLBK, 32'h1388);
      wr(`CES_A_MAXSPD, 32'h0bb8);
      wr(`CES_A_RETRY, 32'h0);
      wr(`CES_A_CTRL, 32'h3);
      host_u.send(1'b0, 3, 2);
      wt(4);
      co(6'h00);
      wr(`CES_A_CTRL, 32'h0);
      host_u.send(1'b0, 3, 2);
      wt(4);
      co(6'h00);
      wr(`CES_A_CTRL, 32'h1);
      host_u.send(1'b0, 1, 2);
      wt(4);
      co(6'b001001);
      chk({16'h0, spd}, 32'h0bb8);
      host_u.send(1'b1, 1, 2);
      wt(4);
      chk({10'h0, so, spd}, 32'h03e8);
      wr(`CES_A_FALLBK, 32'h2ee1);
      rc(`CES_A_FALLBK, 32'h1388);
      wr(`CES_A_FALLBK, 32'h270f);
      host_u.send(1'b0, 1, 2);
      cmd <= 16'h07d0;
      wt(4);
      chk({16'h0, spd}, 32'h03e8);
      host_u.send(1'b1, 1, 2);
      wt(4);
      chk({10'h0, so, spd}, 32'h07d0);
   endtask : t_fallback
   task t_loss;
      wr(`CES_A_CTRL, 32'h0);
      wr(`CES_A_STOPSEL, 32'h2);
      wr(`CES_A_CHECK, 32'h3);
      wr(`CES_A_CTRL, 32'h1);
      wt(100);
      co(6'h00);
      host_u.send(1'b1, 5, 20);
      wt(0);
      co(6'h00);
      wt(60);
      co(6'b000010);
      @(posedge clk_i);
      stopped <= 1'b1;
      wt(3);
      co(6'b100010);
      host_u.send(1'b1, 1, 2);
      wt(4);
      co(6'h00);
      @(posedge clk_i);
      stopped <= 1'b0;
      wr(`CES_A_CHECK, 32'h270f);
      wt(100);
      co(6'h00);
   endtask : t_loss
   task t_lock;
      wr(`CES_A_CTRL, 32'h0);
      wr(`CES_A_EXTDISP, 32'h1);
      wr(`CES_A_RETRY, 32'h5);
      rc(`CES_A_RETRY, 32'h0);
      wr(`CES_A_EXTDISP, 32'h0);
      wr(`CES_A_RETRY, 32'h0b);
      rc(`CES_A_RETRY, 32'h0);
      wr(`CES_A_RETRY, 32'h0a);
      rc(`CES_A_RETRY, 32'h0a);
   endtask : t_lock
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_zero;
      t_retry;
      t_fallback;
      t_loss;
      t_lock;
      test_done;
   end
   // the whole run is under a thousand cycles, so this only trips on a hang
   initial
   begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      test_done;
   end
endmodule : tb_comm_error_supervisor
